// ### inc/lpsci_pkg.sv
`default_nettype none
package lpsci_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 13;
  localparam int COL_W = 9;
  localparam int DIES = 2;
  localparam int BANKS = 4;
  localparam int AUTO_CLOSE_BIT = 10;
  // Mode register fields
  localparam int MODE_BL_LSB = 0;
  localparam int MODE_CL_LSB = 4;
  localparam logic [2:0] BL_ONE = 3'h0;
  localparam logic [2:0] BL_TWO = 3'h1;
  localparam logic [2:0] BL_FOUR = 3'h2;
  localparam logic [2:0] BL_EIGHT = 3'h3;
  localparam logic [2:0] BL_PAGE = 3'h7;
  localparam logic [2:0] CL_THREE = 3'h3;
  localparam logic [1:0] BANK_BASE_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT_MODE = 2'h2;
  // Command code is {row_strobe_n, col_strobe_n, write_strobe_n} with a die selected
  typedef enum logic [2:0] {
    CMD_LOAD_MODE = 3'h0,
    CMD_REFRESH = 3'h1,
    CMD_PRECHARGE = 3'h2,
    CMD_ACTIVATE = 3'h3,
    CMD_WRITE = 3'h4,
    CMD_READ = 3'h5,
    CMD_BURST_STOP = 3'h6,
    CMD_NOP = 3'h7
  } lpsci_cmd_t;
  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_ACT_PD = 3'h1,
    PM_SUSPEND = 3'h3,
    PM_PRE_PD = 3'h2,
    PM_SELF_REF = 3'h6
  } lpsci_pm_t;
  // Controller register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_WDATA = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int CMD_BANK_LSB = 13;
  localparam int CMD_DIE_BIT = 15;
  localparam int CMD_CODE_LSB = 16;
  localparam int CMD_SELF_REF_BIT = 31;
  localparam int CTRL_CKE_BIT = 0;
  localparam int CTRL_LMASK_BIT = 1;
  localparam int CTRL_HMASK_BIT = 2;
  localparam int CTRL_DRIVE_BIT = 3;
  localparam int CTRL_LAT_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0021;
  localparam int STAT_RVALID_BIT = 16;
  localparam int STAT_CKE_BIT = 17;
endpackage
`default_nettype wire

// ### inc/lpsci_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lpsci_if;
  logic cke;
  logic die_select_0_n;
  logic die_select_1_n;
  logic row_strobe_n;
  logic col_strobe_n;
  logic write_strobe_n;
  logic bank_select_0;
  logic bank_select_1;
  logic [lpsci_pkg::ADDR_W-1:0] addr_lines;
  logic low_byte_mask;
  logic high_byte_mask;
  logic [lpsci_pkg::DATA_W-1:0] ctl_dq_o;
  logic ctl_dq_oe;
  logic [lpsci_pkg::DATA_W-1:0] dev_dq_o;
  logic [1:0] dev_dq_oe;
  logic [lpsci_pkg::DATA_W-1:0] data_lines;

  // Shared bus level; an undriven lane reads as zero
  always_comb begin
    data_lines = '0;
    if (ctl_dq_oe) begin
      data_lines = ctl_dq_o;
    end
    if (dev_dq_oe[0]) begin
      data_lines[7:0] = dev_dq_o[7:0];
    end
    if (dev_dq_oe[1]) begin
      data_lines[15:8] = dev_dq_o[15:8];
    end
  end

  modport dev (
    input cke, die_select_0_n, die_select_1_n, row_strobe_n, col_strobe_n,
    input write_strobe_n, bank_select_0, bank_select_1, addr_lines,
    input low_byte_mask, high_byte_mask, data_lines,
    output dev_dq_o, dev_dq_oe
  );
  modport ctl (
    output cke, die_select_0_n, die_select_1_n, row_strobe_n, col_strobe_n,
    output write_strobe_n, bank_select_0, bank_select_1, addr_lines,
    output low_byte_mask, high_byte_mask, ctl_dq_o, ctl_dq_oe,
    input data_lines
  );
endinterface
`default_nettype wire

// ### rtl/lpsci_device.sv
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module lpsci_device #(
  parameter int ROW_KEEP = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  lpsci_if.dev pins,
  output lpsci_pkg::lpsci_pm_t power_state,
  output logic burst_busy
);
  localparam int DW = lpsci_pkg::DATA_W;
  localparam int AW = lpsci_pkg::ADDR_W;
  localparam int CW = lpsci_pkg::COL_W;
  localparam int ND = lpsci_pkg::DIES;
  localparam int NB = lpsci_pkg::BANKS;
  localparam int MEM_AW = 1 + 2 + ROW_KEEP + CW;

  typedef struct packed {
    lpsci_pkg::lpsci_pm_t pm;
    logic [ND-1:0][NB-1:0] open;
    logic [ND-1:0][NB-1:0][AW-1:0] row;
    logic [ND-1:0][AW-1:0] mode;
    logic [ND-1:0][AW-1:0] ext_mode;
    logic b_act;
    logic b_wr;
    logic b_die;
    logic [1:0] b_bank;
    logic [CW-1:0] b_col;
    logic [CW-1:0] b_wrap;
    logic [CW:0] b_left;
    logic b_close;
    logic rd_lat3;
    logic [2:0] pipe_v;
    logic [2:0][DW-1:0] pipe_d;
    logic [1:0] mask_d1;
    logic [1:0] mask_d2;
  } lpsci_dev_st_t;

  lpsci_dev_st_t s_q;
  lpsci_dev_st_t s_d;
  // Storage keeps only the low row bits to stay small; rows alias modulo 2**ROW_KEEP
  logic [DW-1:0] mem [0:(1<<MEM_AW)-1];

  logic run;
  logic cs_any;
  logic die;
  logic [1:0] bank;
  lpsci_pkg::lpsci_cmd_t cmd;
  logic rw_new;
  logic xfer;
  logic x_die;
  logic [1:0] x_bank;
  logic [CW-1:0] x_col;
  logic [CW-1:0] x_wrap;
  logic [CW:0] x_left;
  logic x_wr;
  logic x_close;
  logic [MEM_AW-1:0] x_addr;
  logic [1:0] lane_we;
  logic [ND-1:0][NB-1:0] open_tmp;

  function automatic logic [CW:0] burst_len(input logic [2:0] code);
    logic [CW:0] len;
    len = (CW+1)'(1);
    case (code)
      lpsci_pkg::BL_TWO: len = (CW+1)'(2);
      lpsci_pkg::BL_FOUR: len = (CW+1)'(4);
      lpsci_pkg::BL_EIGHT: len = (CW+1)'(8);
      lpsci_pkg::BL_PAGE: len = (CW+1)'(1 << CW);
      default: len = (CW+1)'(1);
    endcase
    return len;
  endfunction

  // ------------------------------------------------------------------
  // Decode and next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    lane_we = 2'b00;
    // Die 0 wins if both selects are low; the controller never does that
    cs_any = !pins.die_select_0_n || !pins.die_select_1_n;
    die = pins.die_select_0_n;
    bank = {pins.bank_select_1, pins.bank_select_0};
    cmd = lpsci_pkg::lpsci_cmd_t'({pins.row_strobe_n, pins.col_strobe_n,
                                   pins.write_strobe_n});
    // Nothing but the clock gate is looked at outside the run state
    run = (s_q.pm == lpsci_pkg::PM_RUN) && pins.cke;
    rw_new = run && cs_any &&
             (cmd == lpsci_pkg::CMD_READ || cmd == lpsci_pkg::CMD_WRITE);
    xfer = rw_new || (run && s_q.b_act &&
           !(cs_any && cmd == lpsci_pkg::CMD_BURST_STOP));
    x_die = s_q.b_die;
    x_bank = s_q.b_bank;
    x_col = s_q.b_col;
    x_wrap = s_q.b_wrap;
    x_left = s_q.b_left;
    x_wr = s_q.b_wr;
    x_close = s_q.b_close;
    if (rw_new) begin
      x_die = die;
      x_bank = bank;
      x_col = pins.addr_lines[CW-1:0];
      x_left = burst_len(s_q.mode[die][lpsci_pkg::MODE_BL_LSB +: 3]);
      x_wrap = CW'(x_left - (CW+1)'(1));
      x_wr = (cmd == lpsci_pkg::CMD_WRITE);
      x_close = pins.addr_lines[lpsci_pkg::AUTO_CLOSE_BIT];
    end
    x_addr = {x_die, x_bank, s_q.row[x_die][x_bank][ROW_KEEP-1:0], x_col};

    if (run) begin
      // Read mask reaches the drivers two edges after it is sampled
      s_d.mask_d1 = {pins.high_byte_mask, pins.low_byte_mask};
      s_d.mask_d2 = s_q.mask_d1;
      s_d.pipe_v = {s_q.pipe_v[1:0], xfer && !x_wr};
      s_d.pipe_d = {s_q.pipe_d[1:0], mem[x_addr]};
      if (rw_new && !x_wr) begin
        s_d.rd_lat3 = (s_q.mode[die][lpsci_pkg::MODE_CL_LSB +: 3] ==
                       lpsci_pkg::CL_THREE);
      end
      if (xfer && x_wr) begin
        lane_we = ~{pins.high_byte_mask, pins.low_byte_mask};
      end
      if (cs_any && cmd == lpsci_pkg::CMD_BURST_STOP) begin
        s_d.b_act = 1'b0;
      end
      if (xfer) begin
        s_d.b_die = x_die;
        s_d.b_bank = x_bank;
        s_d.b_wr = x_wr;
        s_d.b_close = x_close;
        s_d.b_wrap = x_wrap;
        s_d.b_col = (x_col & ~x_wrap) | ((x_col + CW'(1)) & x_wrap);
        s_d.b_left = x_left - (CW+1)'(1);
        s_d.b_act = (x_left != (CW+1)'(1));
        if (x_left == (CW+1)'(1) && x_close) begin
          s_d.open[x_die][x_bank] = 1'b0;
        end
      end
      if (cs_any) begin
        unique case (cmd)
          lpsci_pkg::CMD_ACTIVATE: begin
            s_d.open[die][bank] = 1'b1;
            s_d.row[die][bank] = pins.addr_lines;
          end
          lpsci_pkg::CMD_PRECHARGE: begin
            if (pins.addr_lines[lpsci_pkg::AUTO_CLOSE_BIT]) begin
              s_d.open[die] = '0;
            end else begin
              s_d.open[die][bank] = 1'b0;
            end
          end
          lpsci_pkg::CMD_LOAD_MODE: begin
            if (bank == lpsci_pkg::BANK_BASE_MODE) begin
              s_d.mode[die] = pins.addr_lines;
            end else if (bank == lpsci_pkg::BANK_EXT_MODE) begin
              s_d.ext_mode[die] = pins.addr_lines;
            end
          end
          lpsci_pkg::CMD_REFRESH,
          lpsci_pkg::CMD_READ,
          lpsci_pkg::CMD_WRITE,
          lpsci_pkg::CMD_BURST_STOP,
          lpsci_pkg::CMD_NOP: begin
          end
        endcase
      end
    end

    // ------------------------------------------------------------------
    // Clock gate: entry choice depends on what is in flight
    // ------------------------------------------------------------------
    open_tmp = s_q.open;
    if (s_q.pm != lpsci_pkg::PM_RUN) begin
      if (pins.cke) begin
        s_d.pm = lpsci_pkg::PM_RUN;
      end
    end else if (!pins.cke) begin
      // Frozen burst and pipeline resume intact when the gate rises
      if (s_q.b_act || s_q.pipe_v != 3'b000) begin
        s_d.pm = lpsci_pkg::PM_SUSPEND;
      end else if (open_tmp != '0) begin
        s_d.pm = lpsci_pkg::PM_ACT_PD;
      end else if (cs_any && cmd == lpsci_pkg::CMD_REFRESH) begin
        s_d.pm = lpsci_pkg::PM_SELF_REF;
      end else begin
        s_d.pm = lpsci_pkg::PM_PRE_PD;
      end
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst && lane_we[0]) begin
      mem[x_addr][7:0] <= pins.data_lines[7:0];
    end
    if (!rst && lane_we[1]) begin
      mem[x_addr][15:8] <= pins.data_lines[15:8];
    end
  end

  // ------------------------------------------------------------------
  // Read drivers
  // ------------------------------------------------------------------
  logic rd_valid;
  assign rd_valid = s_q.rd_lat3 ? s_q.pipe_v[2] : s_q.pipe_v[1];
  assign pins.dev_dq_o = s_q.rd_lat3 ? s_q.pipe_d[2] : s_q.pipe_d[1];
  // Drivers are off whenever the clock gate holds the device out of run
  assign pins.dev_dq_oe = {2{rd_valid && s_q.pm == lpsci_pkg::PM_RUN}} &
                          ~s_q.mask_d2;
  assign power_state = s_q.pm;
  assign burst_busy = s_q.b_act;
endmodule
`default_nettype wire

// ### rtl/lpsci_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module lpsci_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  lpsci_if.ctl pins
);
  typedef struct packed {
    logic issue;
    logic [2:0] code;
    logic die;
    logic [1:0] bank;
    logic [12:0] addr;
    logic [15:0] wdata;
    logic [31:0] ctrl;
    logic [2:0] rd_cnt;
    logic [15:0] rdata;
    logic rvalid;
  } lpsci_ctl_st_t;

  lpsci_ctl_st_t s_q;
  lpsci_ctl_st_t s_d;
  logic wr_acc;
  logic rd_acc;
  logic mapped;

  // ------------------------------------------------------------------
  // Register access and command issue
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    wr_acc = psel && penable && pwrite;
    rd_acc = psel && penable && !pwrite;
    mapped = paddr == lpsci_pkg::REG_CMD || paddr == lpsci_pkg::REG_WDATA ||
             paddr == lpsci_pkg::REG_CTRL || paddr == lpsci_pkg::REG_STATUS;
    s_d.issue = 1'b0;
    if (rd_acc && paddr == lpsci_pkg::REG_STATUS) begin
      s_d.rvalid = 1'b0;
    end
    if (s_q.rd_cnt != 3'h0) begin
      s_d.rd_cnt = s_q.rd_cnt - 3'h1;
      // Capture lands exactly latency edges after the device took the read
      if (s_q.rd_cnt == 3'h1) begin
        s_d.rdata = pins.data_lines;
        s_d.rvalid = 1'b1;
      end
    end
    if (wr_acc) begin
      unique case (paddr)
        lpsci_pkg::REG_CMD: begin
          s_d.issue = 1'b1;
          s_d.code = pwdata[lpsci_pkg::CMD_CODE_LSB +: 3];
          s_d.die = pwdata[lpsci_pkg::CMD_DIE_BIT];
          s_d.bank = pwdata[lpsci_pkg::CMD_BANK_LSB +: 2];
          s_d.addr = pwdata[12:0];
          if (pwdata[lpsci_pkg::CMD_CODE_LSB +: 3] == lpsci_pkg::CMD_READ) begin
            s_d.rd_cnt = {1'b0, s_q.ctrl[lpsci_pkg::CTRL_LAT_LSB +: 2]} + 3'h1;
          end
          // Self refresh needs the gate low at the very edge of the refresh command
          if (pwdata[lpsci_pkg::CMD_CODE_LSB +: 3] == lpsci_pkg::CMD_REFRESH &&
              pwdata[lpsci_pkg::CMD_SELF_REF_BIT]) begin
            s_d.ctrl[lpsci_pkg::CTRL_CKE_BIT] = 1'b0;
          end
        end
        lpsci_pkg::REG_WDATA: s_d.wdata = pwdata[15:0];
        lpsci_pkg::REG_CTRL: s_d.ctrl = {26'h0, pwdata[5:0]};
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{code: lpsci_pkg::CMD_NOP, ctrl: lpsci_pkg::CTRL_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Bus answer
  // ------------------------------------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      lpsci_pkg::REG_CMD: prdata = {13'h0, s_q.code, s_q.die, s_q.bank, s_q.addr};
      lpsci_pkg::REG_WDATA: prdata = {16'h0, s_q.wdata};
      lpsci_pkg::REG_CTRL: prdata = s_q.ctrl;
      lpsci_pkg::REG_STATUS: prdata = {14'h0, s_q.ctrl[lpsci_pkg::CTRL_CKE_BIT],
                                       s_q.rvalid, s_q.rdata};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ------------------------------------------------------------------
  // Pins: one die selected for one cycle per command, else deselect
  // ------------------------------------------------------------------
  assign pins.die_select_0_n = !(s_q.issue && !s_q.die);
  assign pins.die_select_1_n = !(s_q.issue && s_q.die);
  assign pins.row_strobe_n = s_q.code[2];
  assign pins.col_strobe_n = s_q.code[1];
  assign pins.write_strobe_n = s_q.code[0];
  assign pins.bank_select_0 = s_q.bank[0];
  assign pins.bank_select_1 = s_q.bank[1];
  assign pins.addr_lines = s_q.addr;
  assign pins.cke = s_q.ctrl[lpsci_pkg::CTRL_CKE_BIT];
  assign pins.low_byte_mask = s_q.ctrl[lpsci_pkg::CTRL_LMASK_BIT];
  assign pins.high_byte_mask = s_q.ctrl[lpsci_pkg::CTRL_HMASK_BIT];
  assign pins.ctl_dq_o = s_q.wdata;
  assign pins.ctl_dq_oe = s_q.ctrl[lpsci_pkg::CTRL_DRIVE_BIT];
endmodule
`default_nettype wire

// ### test/lpsci_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lpsci_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cke,
  input wire logic die_select_0_n,
  input wire logic die_select_1_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic bank_select_0,
  input wire logic bank_select_1,
  input wire logic [lpsci_pkg::ADDR_W-1:0] addr_lines,
  input wire logic low_byte_mask,
  input wire logic high_byte_mask,
  input wire logic ctl_dq_oe,
  input wire logic [1:0] dev_dq_oe
);
  // ------------------------------------------------------------
  // Command tracking
  // ------------------------------------------------------------
  // Latency is tracked from base mode loads; the bench loads both dies alike
  logic cke_q;
  logic [1:0] lat_q;
  logic sel;
  logic live;
  logic [2:0] code;
  logic rd2;
  logic rd3;
  logic mode_ld;
  assign sel = !die_select_0_n || !die_select_1_n;
  assign code = {row_strobe_n, col_strobe_n, write_strobe_n};
  assign live = cke && cke_q && sel;
  assign mode_ld = live && code == lpsci_pkg::CMD_LOAD_MODE && !bank_select_0 && !bank_select_1;
  assign rd2 = live && code == lpsci_pkg::CMD_READ && lat_q == 2'h2;
  assign rd3 = live && code == lpsci_pkg::CMD_READ && lat_q == 2'h3;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cke_q <= 1'b0;
      lat_q <= 2'h2;
    end else begin
      cke_q <= cke;
      if (mode_ld) begin
        lat_q <= (addr_lines[6:4] == 3'h3) ? 2'h3 : 2'h2;
      end
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_one_die;
    !(!die_select_0_n && !die_select_1_n);
  endproperty
  a_one_die: assert property (p_one_die) else $error("both dies selected");
  property p_sel_pulse;
    sel |=> !sel;
  endproperty
  a_sel_pulse: assert property (p_sel_pulse) else $error("select held");
  property p_bus_owner;
    !(ctl_dq_oe && dev_dq_oe != 2'h0);
  endproperty
  a_bus_owner: assert property (p_bus_owner) else $error("bus driven twice");
  property p_lat2;
    rd2 && !low_byte_mask |-> ##2 dev_dq_oe[0];
  endproperty
  a_lat2: assert property (p_lat2) else $error("latency two word missing");
  property p_lat3;
    rd3 ##1 !low_byte_mask |-> ##2 dev_dq_oe[0];
  endproperty
  a_lat3: assert property (p_lat3) else $error("latency three word missing");
  property p_lat3_early;
    rd3 |=> (dev_dq_oe == 2'h0) [*2];
  endproperty
  a_lat3_early: assert property (p_lat3_early) else $error("word too early");
  property p_mask2;
    rd2 && high_byte_mask |-> ##2 !dev_dq_oe[1];
  endproperty
  a_mask2: assert property (p_mask2) else $error("masked lane driven");
  property p_mask3;
    rd3 ##1 high_byte_mask |-> ##2 !dev_dq_oe[1];
  endproperty
  a_mask3: assert property (p_mask3) else $error("masked lane driven");
  property p_gate;
    !cke |=> dev_dq_oe == 2'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("driving while gated");
  c_rd2: cover property (rd2);
  c_rd3: cover property (rd3);
  c_mode: cover property (mode_ld);
  c_gate: cover property (!cke ##1 cke);
endmodule
`default_nettype wire

// ### test/lp_sdram_pin_command_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
module lp_sdram_pin_command_interface_test;
  logic ref_clk;
  logic rst;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  lpsci_pkg::lpsci_pm_t power_state;
  logic burst_busy;
  int n_errors = 0;
  int check_count = 0;
  int seed;
  logic [1:0] lat;
  logic [12:0] row;
  logic [8:0] col;
  logic [15:0] a, b, c, m;
  logic [32:0] exp_q[$];
  lpsci_if bus();
  lpsci_ctrl i_lpsci_ctrl (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(bus));
  lpsci_device #(.ROW_KEEP(2)) i_lpsci_device (.ref_clk(ref_clk), .rst(rst), .pins(bus),
    .power_state(power_state), .burst_busy(burst_busy));
  lpsci_assertions i_lpsci_assertions (.ref_clk(ref_clk), .rst(rst), .cke(bus.cke),
    .die_select_0_n(bus.die_select_0_n), .die_select_1_n(bus.die_select_1_n),
    .row_strobe_n(bus.row_strobe_n), .col_strobe_n(bus.col_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .bank_select_0(bus.bank_select_0),
    .bank_select_1(bus.bank_select_1), .addr_lines(bus.addr_lines),
    .low_byte_mask(bus.low_byte_mask), .high_byte_mask(bus.high_byte_mask),
    .ctl_dq_oe(bus.ctl_dq_oe), .dev_dq_oe(bus.dev_dq_oe));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Starts one edge late so psel never drops and rises in one time step
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [32:0] exp);
    exp_q.push_back(exp);
    apb(1'b0, ad, 32'h0);
  endtask
  task automatic ctl(input logic drv, input logic hm, input logic lm, input logic ck);
    apb(1'b1, lpsci_pkg::REG_CTRL, {26'h0, lat, drv, hm, lm, ck});
  endtask
  task automatic cmd(input logic [2:0] cd, input logic die, input logic [1:0] bk,
                     input logic [12:0] ad);
    apb(1'b1, lpsci_pkg::REG_CMD, {13'h0, cd, die, bk, ad});
  endtask
  task automatic mode(input logic [1:0] bk, input logic [2:0] cl);
    for (int d = 0; d < 2; d++) begin
      cmd(lpsci_pkg::CMD_LOAD_MODE, d[0], bk, {6'h0, cl, 1'b0, lpsci_pkg::BL_ONE});
    end
  endtask
  task automatic wrw(input logic die, input logic lm, input logic [15:0] d);
    apb(1'b1, lpsci_pkg::REG_WDATA, {16'h0, d});
    ctl(1'b1, 1'b0, lm, 1'b1);
    cmd(lpsci_pkg::CMD_WRITE, die, 2'h1, {4'h0, col});
    ctl(1'b0, 1'b0, 1'b0, 1'b1);
  endtask
  task automatic rdw(input logic die, input logic hm, input logic [15:0] d);
    ctl(1'b0, hm, 1'b0, 1'b1);
    cmd(lpsci_pkg::CMD_READ, die, 2'h1, {4'h0, col});
    repeat (8) @(posedge ref_clk);
    rd(lpsci_pkg::REG_STATUS, {17'h3, d});
  endtask
  task automatic pm(input lpsci_pkg::lpsci_pm_t exp);
    for (int i = 0; i < 10 && power_state !== exp; i++) begin
      @(posedge ref_clk);
    end
    check(33'(power_state), 33'(exp));
  endtask
  task automatic gate(input lpsci_pkg::lpsci_pm_t exp);
    ctl(1'b0, 1'b0, 1'b0, 1'b0);
    pm(exp);
    ctl(1'b0, 1'b0, 1'b0, 1'b1);
    pm(lpsci_pkg::PM_RUN);
  endtask
  // ------------------------------------------------------------
  // Read checker and watchdog
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    summarize();
  end
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    seed = 32'h816226cd;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    lat = 2'h2;
    rst = 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(lpsci_pkg::REG_CTRL, {1'b0, lpsci_pkg::CTRL_RESET});
    rd(lpsci_pkg::REG_STATUS, 33'h0_0002_0000);
    rd(8'h10, {1'b1, 32'h0});
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      lat = (k == 0) ? 2'h2 : 2'h3;
      mode(2'h0, {1'b0, lat});
      ctl(1'b0, 1'b0, 1'b0, 1'b1);
      row = 13'($random(seed));
      col = 9'($random(seed));
      a = 16'($random(seed));
      b = 16'($random(seed));
      c = 16'($random(seed));
      m = {b[15:8], a[7:0]};
      cmd(lpsci_pkg::CMD_ACTIVATE, 1'b0, 2'h1, row);
      cmd(lpsci_pkg::CMD_ACTIVATE, 1'b1, 2'h1, row);
      wrw(1'b0, 1'b0, a);
      wrw(1'b0, 1'b1, b);
      wrw(1'b1, 1'b0, c);
      rdw(1'b0, 1'b0, m);
      rdw(1'b1, 1'b0, c);
      rdw(1'b0, 1'b1, {8'h0, m[7:0]});
      $display("test data latency %0d done", lat);
    end
    lat = 2'h2;
    mode(2'h0, 3'h2);
    mode(2'h1, 3'h3);
    mode(lpsci_pkg::BANK_EXT_MODE, 3'h3);
    rdw(1'b1, 1'b0, c);
    $display("test mode select done");
    cmd(lpsci_pkg::CMD_PRECHARGE, 1'b0, 2'h0, 13'h400);
    cmd(lpsci_pkg::CMD_PRECHARGE, 1'b1, 2'h0, 13'h400);
    gate(lpsci_pkg::PM_PRE_PD);
    cmd(lpsci_pkg::CMD_ACTIVATE, 1'b0, 2'h2, row);
    cmd(lpsci_pkg::CMD_PRECHARGE, 1'b0, 2'h3, 13'h0);
    gate(lpsci_pkg::PM_ACT_PD);
    // Address bit ten is bit one of the top nibble
    cmd(lpsci_pkg::CMD_READ, 1'b0, 2'h2, {4'h2, col});
    repeat (8) @(posedge ref_clk);
    gate(lpsci_pkg::PM_PRE_PD);
    $display("test power done");
    // Full page runs 512 words before it ends by itself, so the gate always lands mid burst
    for (int d = 0; d < 2; d++) begin
      cmd(lpsci_pkg::CMD_LOAD_MODE, d[0], 2'h0, {6'h0, 3'h2, 1'b0, lpsci_pkg::BL_PAGE});
    end
    cmd(lpsci_pkg::CMD_READ, 1'b0, 2'h2, {4'h0, col});
    ctl(1'b0, 1'b0, 1'b0, 1'b0);
    pm(lpsci_pkg::PM_SUSPEND);
    check(33'(burst_busy), 33'h1);
    ctl(1'b0, 1'b0, 1'b0, 1'b1);
    pm(lpsci_pkg::PM_RUN);
    cmd(lpsci_pkg::CMD_BURST_STOP, 1'b0, 2'h2, 13'h0);
    repeat (2) @(posedge ref_clk);
    check(33'(burst_busy), 33'h0);
    apb(1'b1, lpsci_pkg::REG_CMD, {1'b1, 12'h0, lpsci_pkg::CMD_REFRESH, 16'h0});
    pm(lpsci_pkg::PM_SELF_REF);
    ctl(1'b0, 1'b0, 1'b0, 1'b1);
    pm(lpsci_pkg::PM_RUN);
    $display("test burst suspend done");
    summarize();
  end
endmodule
`default_nettype wire
